// >>> inc/cabr_consts.vh
/*
 Holds the register offsets, field positions, reset values and mode codes of the
 circular and bit-reversed address generator. Assumes it is included by bare name
 into each design file that needs it.
*/
// Function
// - X pointer select in control bits 3..0; X circular needs select not 15 and bit 15.
// - Y pointer select in control bits 7..4; Y circular needs select not 15 and bit 14.
// - Circular correction applies to whichever working register the select field names.
// - Boundary check uses less-than and greater-than, so overshooting steps still wrap.
// - Corrected address written back only for pre or post modify; register offset keeps pointer.
// - Bit-reversed stepping exists only in the X generator and only for writes.
// - Only the modifier is bit reversed; pointer addresses stay in normal order.
// - Bit reversal needs select not 15, reverse enable set, and pre or post increment.
// - Reverse modifier holds a 15-bit pivot in bits 14..0, usually half the buffer.
// - Bit-reversed addresses are word addresses; bit 0 cleared, pivot scaled to bytes.
// - Byte writes and other modes get normal addresses even with reversal enabled.
// - Under reversal the pointer is combined with the pivot; mode increment ignored.
// - With both enabled, reversal wins on X writes; X read circular keeps working.
// - For 16 entries the reversed index mirrors the four index bits.
// - Each space has its own 16-bit start and end registers bounding its buffer.
// - Length follows from end minus start; longest buffer is 32K words.
`ifndef CABR_CONSTS_VH
`define CABR_CONSTS_VH

// Byte offsets on the register bus.
`define CABR_OFS_MODE_CTRL 5'h00
`define CABR_OFS_REV_MOD 5'h04
`define CABR_OFS_X_START 5'h08
`define CABR_OFS_X_END 5'h0C
`define CABR_OFS_Y_START 5'h10
`define CABR_OFS_Y_END 5'h14
`define CABR_OFS_STATUS 5'h18

// Fields of addr_mode_control.
`define CABR_XSEL_LSB 0
`define CABR_YSEL_LSB 4
`define CABR_BSEL_LSB 8
`define CABR_Y_EN_BIT 14
`define CABR_X_EN_BIT 15
`define CABR_SEL_OFF 4'hF

// Fields of reverse_modifier.
`define CABR_REV_EN_BIT 15
`define CABR_PIVOT_MSB 14

// Status bits.
`define CABR_ST_XR_WRAP 0
`define CABR_ST_XW_WRAP 1
`define CABR_ST_Y_WRAP 2
`define CABR_ST_REV_STEP 3

// Reset values.
`define CABR_RST_MODE_CTRL 16'h0FFF
`define CABR_RST_REV_MOD 16'h0000
`define CABR_RST_BOUND 16'h0000

// Addressing mode codes on the request ports.
`define CABR_MODE_PLAIN 2'h0
`define CABR_MODE_POST 2'h1
`define CABR_MODE_PRE 2'h2
`define CABR_MODE_REGOFS 2'h3

`endif

// >>> rtl/cabr_circ_corr.v
/*
 Holds the combinational circular correction of one address generator channel.
 Assumes the caller supplies the pointer, signed step and mode of one indirect
 access together with the bounds of the buffer of that data space.
*/
`timescale 1ns/1ps
`default_nettype none
`include "cabr_consts.vh"

module cabr_circ_corr (
   input wire [15:0] ptr,
   input wire [15:0] ofs,
   input wire [1:0] mode,
   input wire circ_on,
   input wire [15:0] start_addr,
   input wire [15:0] end_addr,
   input wire force_word,
   output reg [15:0] ea,
   output reg [15:0] wb_val,
   output reg wb_en,
   output reg wrapped
);

   wire [15:0] sum = ptr + ofs;
   wire [15:0] len = end_addr - start_addr + 16'h0001;
   reg [15:0] corr;

   // Wraps the stepped address back into the buffer by its length.
   always @* begin
      corr = sum;
      wrapped = 1'b0;
      if (circ_on) begin
         if (!ofs[15] && (sum > end_addr)) begin
            corr = sum - len;
            wrapped = 1'b1;
         end else if (ofs[15] && (sum < start_addr)) begin
            corr = sum + len;
            wrapped = 1'b1;
         end
         if (force_word) begin
            corr[0] = 1'b0;
         end
      end
   end

   // Chooses the access address and the pointer write-back per mode.
   always @* begin
      ea = ptr;
      wb_val = ptr;
      wb_en = 1'b0;
      case (mode)
         `CABR_MODE_POST: begin
            ea = ptr;
            wb_val = corr;
            wb_en = 1'b1;
         end
         `CABR_MODE_PRE: begin
            ea = corr;
            wb_val = corr;
            wb_en = 1'b1;
         end
         `CABR_MODE_REGOFS: begin
            ea = corr;
            wb_en = 1'b0;
         end
         default: begin
            ea = ptr;
            wb_en = 1'b0;
         end
      endcase
   end

endmodule
`default_nettype wire

// >>> rtl/cabr_top.v
/*
 Holds the address generator extension: an AHB-Lite register slave and three
 request channels (X read, X write, Y) that apply circular correction, with bit-reversed
 correction on X writes only. Assumes one clock, and request ports driven by logic on hclk.
*/
// Decided for this implementation: the AHB-Lite register port and the address map.
`timescale 1ns/1ps
`default_nettype none
`include "cabr_consts.vh"

module cabr_top (
   input wire hclk,
   input wire hresetn,
   input wire clk_en,
   input wire hsel,
   input wire [31:0] haddr,
   input wire [1:0] htrans,
   input wire hwrite,
   input wire [2:0] hsize,
   input wire [31:0] hwdata,
   input wire hready,
   output reg hreadyout,
   output reg hresp,
   output reg [31:0] hrdata,
   input wire xr_req,
   input wire [3:0] xr_reg_num,
   input wire [15:0] xr_ptr,
   input wire [15:0] xr_ofs,
   input wire [1:0] xr_mode,
   output reg xr_done,
   output reg [15:0] xr_ea,
   output reg xr_wb_en,
   output reg [15:0] xr_wb_val,
   input wire xw_req,
   input wire [3:0] xw_reg_num,
   input wire [15:0] xw_ptr,
   input wire [15:0] xw_ofs,
   input wire [1:0] xw_mode,
   input wire xw_byte,
   output reg xw_done,
   output reg [15:0] xw_ea,
   output reg xw_wb_en,
   output reg [15:0] xw_wb_val,
   input wire y_req,
   input wire [3:0] y_reg_num,
   input wire [15:0] y_ptr,
   input wire [15:0] y_ofs,
   input wire [1:0] y_mode,
   output reg y_done,
   output reg [15:0] y_ea,
   output reg y_wb_en,
   output reg [15:0] y_wb_val
);

   parameter Y_WORD_ONLY = 1'b1;

   reg [15:0] mode_ctrl_reg;
   reg [15:0] rev_mod_reg;
   reg [15:0] x_start_reg;
   reg [15:0] x_end_reg;
   reg [15:0] y_start_reg;
   reg [15:0] y_end_reg;
   reg [3:0] status_reg;
   reg [3:0] status_next;
   reg wr_pend_reg;
   reg [4:0] wr_addr_reg;
   reg [15:0] rd_val;

   // Mirrors the bits of a 16-bit word; bit 1 maps to bit 14.
   function [15:0] cabr_rev16;
      input [15:0] v;
      integer i;
      begin
         for (i = 0; i < 16; i = i + 1) begin
            cabr_rev16[i] = v[15 - i];
         end
      end
   endfunction

   // Field decode of the control registers.
   wire [3:0] x_sel = mode_ctrl_reg[`CABR_XSEL_LSB +: 4];
   wire [3:0] y_sel = mode_ctrl_reg[`CABR_YSEL_LSB +: 4];
   wire [3:0] b_sel = mode_ctrl_reg[`CABR_BSEL_LSB +: 4];
   wire x_circ_enable = mode_ctrl_reg[`CABR_X_EN_BIT];
   wire y_circ_enable = mode_ctrl_reg[`CABR_Y_EN_BIT];
   wire rev_enable = rev_mod_reg[`CABR_REV_EN_BIT];
   wire [14:0] rev_pivot = rev_mod_reg[`CABR_PIVOT_MSB:0];

   // Circular correction qualifiers per channel.
   wire x_space_on = x_circ_enable && (x_sel != `CABR_SEL_OFF);
   wire y_space_on = y_circ_enable && (y_sel != `CABR_SEL_OFF);
   wire xr_circ_on = x_space_on && (xr_reg_num == x_sel);
   wire y_circ_on = y_space_on && (y_reg_num == y_sel);

   // Bit-reversed stepping qualifier, X writes only.
   wire xw_incr = ((xw_mode == `CABR_MODE_PRE) || (xw_mode == `CABR_MODE_POST)) &&
      !xw_ofs[15] && (xw_ofs != 16'h0000);
   wire xw_rev_on = rev_enable && (b_sel != `CABR_SEL_OFF) && (xw_reg_num == b_sel) &&
      xw_incr && !xw_byte;
   wire xw_circ_on = x_space_on && (xw_reg_num == x_sel) && !xw_rev_on;

   // Reverse-carry step: pointer kept in normal order, only the modifier reversed.
   wire [15:0] xw_ptr_word = {xw_ptr[15:1], 1'b0};
   wire [15:0] pivot_bytes = {rev_pivot, 1'b0};
   wire [15:0] rev_sum = cabr_rev16(xw_ptr_word) + cabr_rev16(pivot_bytes);
   wire [15:0] rev_next_raw = cabr_rev16(rev_sum);
   wire [15:0] rev_next = {rev_next_raw[15:1], 1'b0};

   wire [15:0] xr_ea_c;
   wire [15:0] xr_wb_c;
   wire xr_wb_en_c;
   wire xr_wrap_c;
   wire [15:0] xw_ea_c;
   wire [15:0] xw_wb_c;
   wire xw_wb_en_c;
   wire xw_wrap_c;
   wire [15:0] y_ea_c;
   wire [15:0] y_wb_c;
   wire y_wb_en_c;
   wire y_wrap_c;

   // X read generator keeps circular correction even under reversal.
   cabr_circ_corr u_xr_corr (
      .ptr(xr_ptr),
      .ofs(xr_ofs),
      .mode(xr_mode),
      .circ_on(xr_circ_on),
      .start_addr(x_start_reg),
      .end_addr(x_end_reg),
      .force_word(1'b0),
      .ea(xr_ea_c),
      .wb_val(xr_wb_c),
      .wb_en(xr_wb_en_c),
      .wrapped(xr_wrap_c)
   );

   // X write generator, overridden below when reversal is active.
   cabr_circ_corr u_xw_corr (
      .ptr(xw_ptr),
      .ofs(xw_ofs),
      .mode(xw_mode),
      .circ_on(xw_circ_on),
      .start_addr(x_start_reg),
      .end_addr(x_end_reg),
      .force_word(1'b0),
      .ea(xw_ea_c),
      .wb_val(xw_wb_c),
      .wb_en(xw_wb_en_c),
      .wrapped(xw_wrap_c)
   );

   // Y generator, word addresses only while its buffer is active.
   cabr_circ_corr u_y_corr (
      .ptr(y_ptr),
      .ofs(y_ofs),
      .mode(y_mode),
      .circ_on(y_circ_on),
      .start_addr(y_start_reg),
      .end_addr(y_end_reg),
      .force_word(Y_WORD_ONLY),
      .ea(y_ea_c),
      .wb_val(y_wb_c),
      .wb_en(y_wb_en_c),
      .wrapped(y_wrap_c)
   );

   // Registers one answer per accepted request on each channel.
   always @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         xr_done <= 1'b0;
         xr_ea <= 16'h0000;
         xr_wb_en <= 1'b0;
         xr_wb_val <= 16'h0000;
         xw_done <= 1'b0;
         xw_ea <= 16'h0000;
         xw_wb_en <= 1'b0;
         xw_wb_val <= 16'h0000;
         y_done <= 1'b0;
         y_ea <= 16'h0000;
         y_wb_en <= 1'b0;
         y_wb_val <= 16'h0000;
      end else if (clk_en) begin
         xr_done <= xr_req;
         xr_wb_en <= xr_req && xr_wb_en_c;
         if (xr_req) begin
            xr_ea <= xr_ea_c;
            xr_wb_val <= xr_wb_c;
         end
         xw_done <= xw_req;
         if (xw_req && xw_rev_on) begin
            xw_ea <= (xw_mode == `CABR_MODE_PRE) ? rev_next : xw_ptr_word;
            xw_wb_val <= rev_next;
            xw_wb_en <= 1'b1;
         end else begin
            xw_wb_en <= xw_req && xw_wb_en_c;
            if (xw_req) begin
               xw_ea <= xw_ea_c;
               xw_wb_val <= xw_wb_c;
            end
         end
         y_done <= y_req;
         y_wb_en <= y_req && y_wb_en_c;
         if (y_req) begin
            y_ea <= y_ea_c;
            y_wb_val <= y_wb_c;
         end
      end
   end

   // Bus decode of the address phase.
   wire addr_ok = (haddr[31:5] == 27'h0000000);
   wire bus_take = hsel && htrans[1] && hready;
   wire bus_wr = bus_take && hwrite;
   wire bus_rd = bus_take && !hwrite;
   wire [4:0] rd_addr = {haddr[4:2], 2'h0};
   wire fwd_hit = wr_pend_reg && (wr_addr_reg == rd_addr);

   // Selects the register value for a read, forwarding a write still in flight.
   always @* begin
      rd_val = 16'h0000;
      if (addr_ok) begin
         case (rd_addr)
            `CABR_OFS_MODE_CTRL: rd_val = mode_ctrl_reg;
            `CABR_OFS_REV_MOD: rd_val = rev_mod_reg;
            `CABR_OFS_X_START: rd_val = x_start_reg;
            `CABR_OFS_X_END: rd_val = x_end_reg;
            `CABR_OFS_Y_START: rd_val = y_start_reg;
            `CABR_OFS_Y_END: rd_val = y_end_reg;
            `CABR_OFS_STATUS: rd_val = {12'h000, status_next};
            default: rd_val = 16'h0000;
         endcase
         if (fwd_hit && (rd_addr < `CABR_OFS_STATUS)) begin
            rd_val = hwdata[15:0];
         end
      end
   end

   // Sticky status: a new event wins over a write-one-to-clear in the same cycle.
   always @* begin
      status_next = status_reg;
      if (wr_pend_reg && (wr_addr_reg == `CABR_OFS_STATUS)) begin
         status_next = status_reg & ~hwdata[3:0];
      end
      if (xr_req && xr_wrap_c) begin
         status_next[`CABR_ST_XR_WRAP] = 1'b1;
      end
      if (xw_req && xw_wrap_c) begin
         status_next[`CABR_ST_XW_WRAP] = 1'b1;
      end
      if (y_req && y_wrap_c) begin
         status_next[`CABR_ST_Y_WRAP] = 1'b1;
      end
      if (xw_req && xw_rev_on) begin
         status_next[`CABR_ST_REV_STEP] = 1'b1;
      end
   end

   // Bus slave: zero wait states, read data registered in the address phase.
   always @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         hreadyout <= 1'b1;
         hresp <= 1'b0;
         hrdata <= 32'h00000000;
         wr_pend_reg <= 1'b0;
         wr_addr_reg <= 5'h00;
      end else if (clk_en) begin
         hreadyout <= 1'b1;
         hresp <= 1'b0;
         wr_pend_reg <= bus_wr && addr_ok;
         if (bus_wr) begin
            wr_addr_reg <= {haddr[4:2], 2'h0};
         end
         if (bus_rd) begin
            hrdata <= {16'h0000, rd_val};
         end
      end
   end

   // Register file, written in the data phase of a bus write.
   always @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         mode_ctrl_reg <= `CABR_RST_MODE_CTRL;
         rev_mod_reg <= `CABR_RST_REV_MOD;
         x_start_reg <= `CABR_RST_BOUND;
         x_end_reg <= `CABR_RST_BOUND;
         y_start_reg <= `CABR_RST_BOUND;
         y_end_reg <= `CABR_RST_BOUND;
         status_reg <= 4'h0;
      end else if (clk_en) begin
         status_reg <= status_next;
         if (wr_pend_reg) begin
            case (wr_addr_reg)
               `CABR_OFS_MODE_CTRL: mode_ctrl_reg <= hwdata[15:0];
               `CABR_OFS_REV_MOD: rev_mod_reg <= hwdata[15:0];
               `CABR_OFS_X_START: x_start_reg <= hwdata[15:0];
               `CABR_OFS_X_END: x_end_reg <= hwdata[15:0];
               `CABR_OFS_Y_START: y_start_reg <= hwdata[15:0];
               `CABR_OFS_Y_END: y_end_reg <= hwdata[15:0];
               default: mode_ctrl_reg <= mode_ctrl_reg;
            endcase
         end
      end
   end

endmodule
`default_nettype wire

// >>> testbench/cabr_core_model.sv
/*
 Holds a model of the processor side that issues one indirect access on a chosen
 address generator channel. Assumes the bench calls issue and that every channel
 shares one set of access fields.
*/
`timescale 1ns/1ps
`default_nettype none

module cabr_core_model (
   input wire logic hclk,
   output logic [2:0] req,
   output logic [3:0] rn,
   output logic [15:0] ptr,
   output logic [15:0] ofs,
   output logic [1:0] md,
   output logic byt
);
   // Fields start idle at time zero.
   initial begin
      req = 3'h0;
      rn = 4'h0;
      ptr = 16'h0000;
      ofs = 16'h0000;
      md = 2'h0;
      byt = 1'b0;
   end

   // Drives one request for one cycle, then shows inverted fields, all but the mode, so nothing stale passes.
   task issue(input logic [1:0] ch, input logic [3:0] r, input logic [15:0] p,
              input logic [15:0] o, input logic [1:0] m, input logic b);
      @(posedge hclk);
      req <= 3'h1 << ch;
      rn <= r;
      ptr <= p;
      ofs <= o;
      md <= m;
      byt <= b;
      @(posedge hclk);
      req <= 3'h0;
      rn <= ~r;
      ptr <= ~p;
      ofs <= ~o;
      byt <= ~b;
   endtask
endmodule
`default_nettype wire

// >>> testbench/cabr_monitor.sv
/*
 Holds the concurrent checks of the address generator channels. Assumes it is
 bound to cabr_top and sees only that module's ports.
*/
`timescale 1ns/1ps
`default_nettype none
`include "cabr_consts.vh"

module cabr_monitor (
   input wire logic hclk,
   input wire logic hresetn,
   input wire logic clk_en,
   input wire logic xr_req,
   input wire logic [15:0] xr_ptr,
   input wire logic [1:0] xr_mode,
   input wire logic xr_done,
   input wire logic [15:0] xr_ea,
   input wire logic xr_wb_en,
   input wire logic xw_req,
   input wire logic [15:0] xw_ptr,
   input wire logic [1:0] xw_mode,
   input wire logic xw_byte,
   input wire logic [15:0] xw_ea,
   input wire logic xw_wb_en,
   input wire logic [15:0] xw_wb_val,
   input wire logic y_req,
   input wire logic [1:0] y_mode,
   input wire logic [15:0] y_ea,
   input wire logic y_wb_en,
   input wire logic [15:0] y_wb_val
);
   default clocking @(posedge hclk); endclocking
   default disable iff (!hresetn);

   // Write-back follows only the pre and post modify modes.
   xr_wb_kind_a: assert property (xr_req && clk_en |=> xr_done && (xr_wb_en ==
      ($past(xr_mode) == `CABR_MODE_POST || $past(xr_mode) == `CABR_MODE_PRE)))
      else $error("X read write-back does not match the mode");
   xr_post_ea_a: assert property (xr_req && clk_en && xr_mode == `CABR_MODE_POST
      |=> xr_ea == $past(xr_ptr)) else $error("X read post-modify address is not the pointer");
   xr_plain_ea_a: assert property (xr_req && clk_en && xr_mode == `CABR_MODE_PLAIN
      |=> xr_ea == $past(xr_ptr) && !xr_wb_en) else $error("X read plain access altered");
   xw_pre_same_a: assert property (xw_req && clk_en && xw_mode == `CABR_MODE_PRE
      |=> xw_wb_en && xw_ea == xw_wb_val) else $error("X write pre-modify address differs");
   xw_byte_norm_a: assert property (xw_req && clk_en && xw_byte
      && xw_mode == `CABR_MODE_POST |=> xw_ea == $past(xw_ptr))
      else $error("X write byte address not normal");
   xw_regofs_keep_a: assert property (xw_req && clk_en && xw_mode == `CABR_MODE_REGOFS
      |=> !xw_wb_en) else $error("X write register offset wrote the pointer");
   y_pre_same_a: assert property (y_req && clk_en && y_mode == `CABR_MODE_PRE
      |=> y_wb_en && y_ea == y_wb_val) else $error("Y pre-modify address differs");
   xr_ea_holds_a: assert property (!xr_req |=> $stable(xr_ea))
      else $error("X read address did not hold");
endmodule

bind cabr_top cabr_monitor cabr_monitor_inst (.hclk, .hresetn, .clk_en, .xr_req, .xr_ptr,
   .xr_mode, .xr_done, .xr_ea, .xr_wb_en, .xw_req, .xw_ptr, .xw_mode, .xw_byte, .xw_ea,
   .xw_wb_en, .xw_wb_val, .y_req, .y_mode, .y_ea, .y_wb_en, .y_wb_val);
`default_nettype wire

// >>> testbench/cabr_top_bench.sv
/*
 Holds the self-checking bench of the address generator: a table of accesses,
 then reset and register cases. Assumes cabr_top, the core model and the monitor.
*/
`timescale 1ns/1ps
`default_nettype none
`include "cabr_consts.vh"

module cabr_top_bench;
   typedef struct packed {
      logic [15:0] ctrl, rev;
      logic [1:0] ch;
      logic [3:0] rn;
      logic [15:0] ptr, ofs;
      logic [1:0] md;
      logic byt;
      logic [15:0] ea;
      logic wen;
      logic [15:0] wb;
   } cabr_row_t;
   // X buffer 0x1000..0x101F, Y buffer 0x2000..0x200F, reversed buffer of 16 words at 0x1000.
   localparam cabr_row_t ROWS [18] = '{
      '{16'h8FF3, 16'h0000, 2'h0, 4'h3, 16'h101E, 16'h0004, 2'h1, 1'h0, 16'h101E, 1'h1, 16'h1002},
      '{16'h8FF3, 16'h0000, 2'h0, 4'h3, 16'h1000, 16'hFFFE, 2'h2, 1'h0, 16'h101E, 1'h1, 16'h101E},
      '{16'h8FF3, 16'h0000, 2'h0, 4'h3, 16'h101C, 16'h0008, 2'h3, 1'h0, 16'h1004, 1'h0, 16'h0000},
      '{16'h8FF3, 16'h0000, 2'h0, 4'h4, 16'h101E, 16'h0004, 2'h1, 1'h0, 16'h101E, 1'h1, 16'h1022},
      '{16'h8FFF, 16'h0000, 2'h0, 4'hF, 16'h101E, 16'h0004, 2'h1, 1'h0, 16'h101E, 1'h1, 16'h1022},
      '{16'h0FF3, 16'h0000, 2'h0, 4'h3, 16'h101E, 16'h0004, 2'h1, 1'h0, 16'h101E, 1'h1, 16'h1022},
      '{16'h8FF3, 16'h0000, 2'h0, 4'h3, 16'h101E, 16'h0004, 2'h0, 1'h0, 16'h101E, 1'h0, 16'h0000},
      '{16'h4F3F, 16'h0000, 2'h2, 4'h3, 16'h200E, 16'h0002, 2'h2, 1'h0, 16'h2000, 1'h1, 16'h2000},
      '{16'h0F3F, 16'h0000, 2'h2, 4'h3, 16'h200E, 16'h0002, 2'h1, 1'h0, 16'h200E, 1'h1, 16'h2010},
      '{16'h03FF, 16'h8008, 2'h1, 4'h3, 16'h1007, 16'h0002, 2'h1, 1'h0, 16'h1006, 1'h1, 16'h1016},
      '{16'h03FF, 16'h8008, 2'h1, 4'h3, 16'h101E, 16'h0002, 2'h2, 1'h0, 16'h1000, 1'h1, 16'h1000},
      '{16'h03FF, 16'h8008, 2'h1, 4'h3, 16'h1007, 16'h0002, 2'h1, 1'h1, 16'h1007, 1'h1, 16'h1009},
      '{16'h03FF, 16'h8008, 2'h1, 4'h3, 16'h1006, 16'h0002, 2'h3, 1'h0, 16'h1008, 1'h0, 16'h0000},
      '{16'h03FF, 16'h8008, 2'h0, 4'h3, 16'h1006, 16'h0002, 2'h1, 1'h0, 16'h1006, 1'h1, 16'h1008},
      '{16'h03FF, 16'h0008, 2'h1, 4'h3, 16'h1006, 16'h0002, 2'h1, 1'h0, 16'h1006, 1'h1, 16'h1008},
      '{16'h03FF, 16'h8008, 2'h1, 4'h3, 16'h1006, 16'h0006, 2'h1, 1'h0, 16'h1006, 1'h1, 16'h1016},
      '{16'h83F3, 16'h8008, 2'h1, 4'h3, 16'h1006, 16'h0002, 2'h1, 1'h0, 16'h1006, 1'h1, 16'h1016},
      '{16'h83F3, 16'h8008, 2'h0, 4'h3, 16'h101E, 16'h0004, 2'h1, 1'h0, 16'h101E, 1'h1, 16'h1002}};
   logic hclk = 1'b0, hresetn = 1'b0, hsel = 1'b0, hwrite = 1'b0, hreadyout, hresp, byt;
   logic ce = 1'b1;
   logic [1:0] htrans = 2'h0, md;
   logic [31:0] haddr = 32'h0, hwdata = 32'h0, hrdata, rd;
   logic [2:0] req;
   wire logic [2:0] dn, wen;
   logic [3:0] rn;
   logic [15:0] ptr, ofs;
   wire logic [2:0][15:0] ea, wb;
   int bad_count = 0, tests_run = 0, cyc = 0;

   cabr_top cabr_top_inst (.hclk, .hresetn, .clk_en(ce), .hsel, .haddr, .htrans, .hwrite,
      .hsize(3'h2), .hwdata, .hready(hreadyout), .hreadyout, .hresp, .hrdata,
      .xr_req(req[0]), .xr_reg_num(rn), .xr_ptr(ptr), .xr_ofs(ofs), .xr_mode(md),
      .xr_done(dn[0]), .xr_ea(ea[0]), .xr_wb_en(wen[0]), .xr_wb_val(wb[0]),
      .xw_req(req[1]), .xw_reg_num(rn), .xw_ptr(ptr), .xw_ofs(ofs), .xw_mode(md), .xw_byte(byt),
      .xw_done(dn[1]), .xw_ea(ea[1]), .xw_wb_en(wen[1]), .xw_wb_val(wb[1]),
      .y_req(req[2]), .y_reg_num(rn), .y_ptr(ptr), .y_ofs(ofs), .y_mode(md),
      .y_done(dn[2]), .y_ea(ea[2]), .y_wb_en(wen[2]), .y_wb_val(wb[2]));
   cabr_core_model cabr_core_model_inst (.hclk, .req, .rn, .ptr, .ofs, .md, .byt);

   // Clock of 4 ns and a cycle ceiling that cuts a hang short.
   always #2 hclk = ~hclk;
   always @(posedge hclk) begin
      cyc <= cyc + 1;
      if (cyc == 5000) begin
         bad_count++;
         give_verdict();
      end
   end

   // Compares one value and counts the result.
   task check(input string nm, input logic [31:0] seen, input logic [31:0] exp);
      tests_run++;
      if (seen !== exp) begin
         bad_count++;
         $display("[ERR] %s expected %h seen %h", nm, exp, seen);
      end
   endtask

   // One single AHB-Lite word transfer; read data is taken at the data phase edge.
   task bus(input logic w, input logic [31:0] a, input logic [31:0] d);
      @(posedge hclk);
      hsel <= 1'b1;
      htrans <= 2'h2;
      haddr <= a;
      hwrite <= w;
      do @(posedge hclk); while (hreadyout !== 1'b1);
      hsel <= 1'b0;
      htrans <= 2'h0;
      hwdata <= d;
      do @(posedge hclk); while (hreadyout !== 1'b1);
      rd = hrdata;
   endtask

   task give_verdict();
      if (bad_count == 0 && tests_run > 0) $display("Simulation passed");
      else $display("Simulation failed");
      $finish;
   endtask

   // Table of accesses, then reset values and register cases.
   initial begin
      repeat (8) @(posedge hclk);
      hresetn <= 1'b1;
      bus(1'b1, `CABR_OFS_X_START, 32'h1000);
      bus(1'b1, `CABR_OFS_X_END, 32'h101F);
      bus(1'b1, `CABR_OFS_Y_START, 32'h2000);
      bus(1'b1, `CABR_OFS_Y_END, 32'h200F);
      foreach (ROWS[i]) begin
         bus(1'b1, `CABR_OFS_MODE_CTRL, {16'h0000, ROWS[i].ctrl});
         bus(1'b1, `CABR_OFS_REV_MOD, {16'h0000, ROWS[i].rev});
         cabr_core_model_inst.issue(ROWS[i].ch, ROWS[i].rn, ROWS[i].ptr, ROWS[i].ofs,
            ROWS[i].md, ROWS[i].byt);
         @(negedge hclk);
         check("done", {31'h0, dn[ROWS[i].ch]}, 32'h1);
         check("ea", {16'h0, ea[ROWS[i].ch]}, {16'h0, ROWS[i].ea});
         check("wb_en", {31'h0, wen[ROWS[i].ch]}, {31'h0, ROWS[i].wen});
         if (ROWS[i].wen) begin
            check("wb", {16'h0, wb[ROWS[i].ch]}, {16'h0, ROWS[i].wb});
         end
      end
      // The table wrapped X reads and Y and made reversed steps; clearing empties status.
      bus(1'b0, `CABR_OFS_STATUS, 32'h0);
      check("status", rd, 32'h0000000D);
      check("hresp", {31'h0, hresp}, 32'h0);
      bus(1'b1, `CABR_OFS_STATUS, 32'h0000000F);
      bus(1'b0, `CABR_OFS_STATUS, 32'h0);
      check("status_clr", rd, 32'h0);
      // A request made while the clock enable is low is not taken and nothing moves.
      ce <= 1'b0;
      cabr_core_model_inst.issue(2'h0, 4'h3, 16'h1000, 16'h0002, `CABR_MODE_POST, 1'b0);
      @(negedge hclk);
      check("frozen_done", {31'h0, dn[0]}, 32'h0);
      check("frozen_ea", {16'h0, ea[0]}, 32'h0000101E);
      @(posedge hclk);
      ce <= 1'b1;
      @(posedge hclk);
      hresetn <= 1'b0;
      @(posedge hclk);
      hresetn <= 1'b1;
      bus(1'b0, `CABR_OFS_MODE_CTRL, 32'h0);
      check("mode_ctrl", rd, 32'h00000FFF);
      bus(1'b0, `CABR_OFS_X_END, 32'h0);
      check("x_end", rd, 32'h0);
      bus(1'b1, `CABR_OFS_REV_MOD, 32'h0000FFFF);
      bus(1'b0, `CABR_OFS_REV_MOD, 32'h0);
      check("rev_mod", rd, 32'h0000FFFF);
      bus(1'b0, 32'h0000001C, 32'h0);
      check("unmapped", rd, 32'h0);
      give_verdict();
   end
endmodule
`default_nettype wire
